// [shared/tmr_pkg.sv]
// Purpose: Shared constants for the 16-bit timer register block.
// Assumes: 8-bit processor data bus, one system clock, byte addresses local to one unit.
// Notes: Offsets are local byte indices because no addresses are given for this unit.
package tmr_pkg;
  // Byte addresses of the unit's registers.
  localparam logic [3:0] ADDR_CNT_LO = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
  localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPB_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPC_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPC_HI = 4'h7;
  localparam logic [3:0] ADDR_CAP_LO = 4'h8;
  localparam logic [3:0] ADDR_CAP_HI = 4'h9;
  localparam logic [3:0] ADDR_MASK = 4'hA;
  localparam logic [3:0] ADDR_FLAGS = 4'hB;
  localparam logic [3:0] ADDR_MODE = 4'hC;
  // Bit positions in the mask and flag registers.
  localparam int BIT_OVF = 0;
  localparam int BIT_MA = 1;
  localparam int BIT_MB = 2;
  localparam int BIT_MC = 3;
  localparam int BIT_CAP = 5;
  // Writable bits of the mask and flag registers.
  localparam logic [7:0] FLAG_MASK = 8'h2F;
  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_MODE = 4'h0;
  // Waveform modes in which the capture register is TOP.
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  // Modes that wrap at MAX and so flag overflow there.
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage : tmr_pkg

// [shared/tmr_cmp_if.sv]
// Purpose: Carries one compare channel's inputs and result.
// Assumes: Same clock as the timer core.
// Notes: One instance per compare channel.
interface tmr_cmp_if;
  logic [15:0] count;   // Counter value being compared.
  logic [15:0] value;   // Compare register value.
  logic block;          // Suppress match this tick.
  logic tick;           // Counter advanced this cycle.
  logic match;          // Registered match pulse.
  modport core (output count, output value, output block, output tick, input match);
  modport chan (input count, input value, input block, input tick, output match);
endinterface : tmr_cmp_if

// [design/tmr_cmp.sv]
// Purpose: One compare channel of the 16-bit timer.
// Assumes: Inputs share the core clock.
// Notes: The match pulse is registered so it lands one clock after equality and the flag two clocks after.
module tmr_cmp (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Channel link to the core.
  tmr_cmp_if.chan cmp
);
  logic match_ff;  // Registered match.
  logic nxt_match; // Next match.

  // Compare on every counter tick unless a counter write blocks it.
  always_comb begin
    nxt_match = cmp.tick && !cmp.block && (cmp.count == cmp.value);
  end

  // Register the match so it lands in the following cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
    end
  end

  assign cmp.match = match_ff;
endmodule : tmr_cmp

// [design/tmr_unit.sv]
// Purpose: Register side of one 16-bit timer/counter unit.
// Assumes: Processor bus of 8 bits with one-cycle read and write strobes.
// Notes: Prescaler, control registers and waveform shaping live elsewhere.
//
// Contract
// - counter accessed as two bytes via holding
// - one holding register shared by all
// - counter write blocks next compare match; code blocks only a tick in the clock after the write
// - compare each register with counter every count
// - compare write commits sixteen bits together
// - capture event copies counter into capture
// - capture register may serve as TOP
// - capture read latches high byte consistently
// - capture irq needs flag, bit5, global
// - channel C irq needs flag, bit3, global
// - channel B irq needs flag, bit2, global
// - channel A irq needs flag, bit1, global
// - overflow irq needs flag, bit0, global
// - flag layout bits 5,3,2,1,0; rest read-only
// - capture flag on event or TOP reach
// - capture flag cleared by vector or one
// - channel C flag set cycle after match
// - channel B flag set cycle after match
// - forced strobes never set match flags
// - B and C flags cleared vector or one
// - A flag cleared likewise, set after match
// - overflow flag at MAX in normal/CTC; code flags it at TOP in the CTC mode with capture as TOP
module tmr_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Processor bus.
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Timer tick and mode from the prescaler and control registers.
  input wire logic count_tick,
  input wire logic global_irq_enable,
  input wire logic capture_use_comparator,
  input wire logic capture_rising_edge,
  // Interrupt vector acknowledge, one bit per flag position.
  input wire logic [5:0] vector_ack,
  // Capture sources from pins.
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  // Interrupt requests and match outputs.
  output logic [5:0] irq_req,
  output logic [2:0] match_pulse,
  output logic [15:0] count_value
);
  // Holding register, counter, compares, capture, mask, flags and mode.
  logic [7:0] hold_ff, nxt_hold;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] cmp_ff [3], nxt_cmp [3];
  logic [15:0] cap_ff, nxt_cap;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] flag_ff, nxt_flag;
  logic [3:0] mode_ff, nxt_mode;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] irq_ff, nxt_irq;
  logic [2:0] mpulse_ff;
  logic block_ff, nxt_block;
  // Three-stage pin sampler; a change counts when stages two and three agree.
  logic [2:0] pin_sync_ff, nxt_pin_sync;
  logic evt_prev_ff, nxt_evt_prev;
  // Derived combinational terms.
  logic cap_is_top, evt_level, evt_edge, at_top, cnt_write;
  logic [15:0] top_val;
  logic [2:0] ch_match;
  logic [7:0] flag_set; // Hardware set terms of the flag register this cycle.

  // Instantiate three compare channels through their interfaces.
  tmr_cmp_if cmp_if [3] ();
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      assign cmp_if[gi].count = cnt_ff;
      assign cmp_if[gi].value = cmp_ff[gi];
      assign cmp_if[gi].block = block_ff;
      assign cmp_if[gi].tick = count_tick;
      assign ch_match[gi] = cmp_if[gi].match;
      tmr_cmp u_cmp (
        .clk(clk),
        .rstn(rstn),
        .cmp(cmp_if[gi])
      );
    end
  endgenerate

  // Decode TOP from the current mode and the capture source from capture_use_comparator.
  always_comb begin
    cap_is_top = (mode_ff == tmr_pkg::MODE_PFC_CAP) || (mode_ff == tmr_pkg::MODE_PC_CAP) ||
                 (mode_ff == tmr_pkg::MODE_CTC_CAP) || (mode_ff == tmr_pkg::MODE_FAST_CAP);
    top_val = cap_is_top ? cap_ff : tmr_pkg::CNT_MAX;
    at_top = count_tick && (cnt_ff == top_val);
    // Only stages two and three are looked at, so the first never feeds logic.
    evt_level = capture_use_comparator ? comparator_out : pin_sync_ff[2];
    // Edge detector compares the agreed level with its own previous value.
    evt_edge = (pin_sync_ff[1] == pin_sync_ff[2]) && (evt_level != evt_prev_ff) &&
               (evt_level == capture_rising_edge);
    cnt_write = bus_wr && ((bus_addr == tmr_pkg::ADDR_CNT_LO));
    // Set terms, only from real events; forced strobes never reach here.
    flag_set = tmr_pkg::RST_BYTE;
    flag_set[tmr_pkg::BIT_MA] = ch_match[0];
    flag_set[tmr_pkg::BIT_MB] = ch_match[1];
    flag_set[tmr_pkg::BIT_MC] = ch_match[2];
    // Overflow at MAX in MODE_NORMAL and MODE_CTC_A, at TOP in every other mode, including MODE_CTC_CAP.
    if ((mode_ff == tmr_pkg::MODE_NORMAL) || (mode_ff == tmr_pkg::MODE_CTC_A)) begin
      flag_set[tmr_pkg::BIT_OVF] = count_tick && (cnt_ff == tmr_pkg::CNT_MAX);
    end else begin
      flag_set[tmr_pkg::BIT_OVF] = at_top;
    end
    flag_set[tmr_pkg::BIT_CAP] = (evt_edge && !cap_is_top) || (cap_is_top && at_top);
  end

  // Next-state logic for all register state.
  always_comb begin
    nxt_hold = hold_ff;
    nxt_cnt = cnt_ff;
    nxt_cmp = cmp_ff;
    nxt_cap = cap_ff;
    nxt_mask = mask_ff;
    nxt_flag = flag_ff;
    nxt_mode = mode_ff;
    nxt_rdata = rdata_ff;
    nxt_block = 1'b0;
    nxt_pin_sync = {pin_sync_ff[1:0], capture_input_pin};
    nxt_evt_prev = ((pin_sync_ff[1] == pin_sync_ff[2]) || capture_use_comparator) ? evt_level : evt_prev_ff;
    // Counting: wrap at TOP, or clear when TOP is the capture register.
    if (count_tick) begin
      nxt_cnt = at_top ? tmr_pkg::RST_WORD : 16'(cnt_ff + tmr_pkg::CNT_ONE);
    end
    // Capture is disconnected when the capture register is TOP.
    if (evt_edge && !cap_is_top) begin
      nxt_cap = cnt_ff;
    end
    // Apply the hardware set terms.
    nxt_flag = flag_ff | flag_set;
    // Clears by vector or by writing one; a set in the same cycle wins.
    for (int i = 0; i < 6; i++) begin
      if (tmr_pkg::FLAG_MASK[i] && (vector_ack[i] ||
          (bus_wr && bus_addr == tmr_pkg::ADDR_FLAGS && bus_wdata[i])) &&
          !flag_set[i]) begin
        nxt_flag[i] = 1'b0;
      end
    end
    // Processor writes: high bytes load the shared holding register, low bytes commit.
    if (bus_wr) begin
      unique case (bus_addr)
        tmr_pkg::ADDR_CNT_HI, tmr_pkg::ADDR_CMPA_HI, tmr_pkg::ADDR_CMPB_HI,
        tmr_pkg::ADDR_CMPC_HI, tmr_pkg::ADDR_CAP_HI: nxt_hold = bus_wdata;
        tmr_pkg::ADDR_CNT_LO: begin
          nxt_cnt = {hold_ff, bus_wdata};
          nxt_block = 1'b1;
        end
        tmr_pkg::ADDR_CMPA_LO: nxt_cmp[0] = {hold_ff, bus_wdata};
        tmr_pkg::ADDR_CMPB_LO: nxt_cmp[1] = {hold_ff, bus_wdata};
        tmr_pkg::ADDR_CMPC_LO: nxt_cmp[2] = {hold_ff, bus_wdata};
        tmr_pkg::ADDR_CAP_LO: nxt_cap = {hold_ff, bus_wdata};
        tmr_pkg::ADDR_MASK: nxt_mask = bus_wdata & tmr_pkg::FLAG_MASK;
        tmr_pkg::ADDR_MODE: nxt_mode = bus_wdata[3:0];
        default: nxt_hold = hold_ff;
      endcase
    end
    // Processor reads: counter and capture low bytes latch the high half, their high bytes return the holding register.
    if (bus_rd) begin
      unique case (bus_addr)
        tmr_pkg::ADDR_CNT_LO: begin
          nxt_rdata = cnt_ff[7:0];
          nxt_hold = cnt_ff[15:8];
        end
        tmr_pkg::ADDR_CAP_LO: begin
          nxt_rdata = cap_ff[7:0];
          nxt_hold = cap_ff[15:8];
        end
        tmr_pkg::ADDR_CMPA_LO: nxt_rdata = cmp_ff[0][7:0];
        tmr_pkg::ADDR_CMPB_LO: nxt_rdata = cmp_ff[1][7:0];
        tmr_pkg::ADDR_CMPC_LO: nxt_rdata = cmp_ff[2][7:0];
        tmr_pkg::ADDR_CMPA_HI: nxt_rdata = cmp_ff[0][15:8];
        tmr_pkg::ADDR_CMPB_HI: nxt_rdata = cmp_ff[1][15:8];
        tmr_pkg::ADDR_CMPC_HI: nxt_rdata = cmp_ff[2][15:8];
        tmr_pkg::ADDR_CNT_HI, tmr_pkg::ADDR_CAP_HI: nxt_rdata = hold_ff;
        tmr_pkg::ADDR_MASK: nxt_rdata = mask_ff;
        tmr_pkg::ADDR_FLAGS: nxt_rdata = flag_ff & tmr_pkg::FLAG_MASK;
        tmr_pkg::ADDR_MODE: nxt_rdata = {4'h0, mode_ff};
        default: nxt_rdata = tmr_pkg::RST_BYTE;
      endcase
    end
    // Requests need flag, enable and the global enable together.
    nxt_irq = nxt_flag[5:0] & mask_ff[5:0] & {6{global_irq_enable}};
  end

  // Register all state; synchronous active-low reset clears everything.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_ff <= tmr_pkg::RST_BYTE;
      cnt_ff <= tmr_pkg::RST_WORD;
      cmp_ff <= '{default: tmr_pkg::RST_WORD};
      cap_ff <= tmr_pkg::RST_WORD;
      mask_ff <= tmr_pkg::RST_BYTE;
      flag_ff <= tmr_pkg::RST_BYTE;
      mode_ff <= tmr_pkg::RST_MODE;
      rdata_ff <= tmr_pkg::RST_BYTE;
      irq_ff <= 6'h00;
      mpulse_ff <= 3'h0;
      block_ff <= 1'b0;
      pin_sync_ff <= 3'h0;
      evt_prev_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      cnt_ff <= nxt_cnt;
      cmp_ff <= nxt_cmp;
      cap_ff <= nxt_cap;
      mask_ff <= nxt_mask;
      flag_ff <= nxt_flag;
      mode_ff <= nxt_mode;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      mpulse_ff <= ch_match;
      block_ff <= nxt_block;
      pin_sync_ff <= nxt_pin_sync;
      evt_prev_ff <= nxt_evt_prev;
    end
  end

  // Outputs straight from flip-flops.
  assign bus_rdata = rdata_ff;
  assign irq_req = irq_ff;
  assign match_pulse = mpulse_ff;
  assign count_value = cnt_ff;
endmodule : tmr_unit

// [dv/tmr_unit_chk.sv]
// Purpose: Port-level assertions for the timer register unit.
// Assumes: One clock and a synchronous active-low reset.
// Notes: Bound to every instance of the unit.
module tmr_unit_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Watched ports.
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic count_tick,
  input wire logic global_irq_enable,
  input wire logic [5:0] irq_req,
  input wire logic [2:0] match_pulse,
  input wire logic [15:0] count_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A low-byte write commits the counter in the next cycle.
  cnt_commit_a: assert property (bus_wr && bus_addr == tmr_pkg::ADDR_CNT_LO
    |=> count_value[7:0] == $past(bus_wdata)) else $error("counter byte not committed");
  // A tick in the clock right after a counter write must not produce a match.
  write_block_a: assert property (bus_wr && bus_addr == tmr_pkg::ADDR_CNT_LO
    |=> ##2 match_pulse == 3'h0) else $error("match not suppressed after counter write");
  // Without a tick or a write the counter stands.
  count_hold_a: assert property (!count_tick && !bus_wr |=> $stable(count_value))
    else $error("counter moved without tick");
  // Read data stands until the next read.
  rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without read");
  // Matches only come from counted ticks.
  match_tick_a: assert property (match_pulse != 3'h0 |-> $past(count_tick, 2))
    else $error("match without tick");
  // Requests need the global enable.
  irq_global_a: assert property (!global_irq_enable [*2] |-> irq_req == 6'h00)
    else $error("request while globally disabled");
  // The unused flag position never requests.
  irq_gap_a: assert property (irq_req[4] == 1'b0)
    else $error("request on unused bit");
  // The counter wraps to zero past its maximum.
  count_wrap_a: assert property (count_tick && !bus_wr && count_value == tmr_pkg::CNT_MAX
    |=> count_value == tmr_pkg::RST_WORD) else $error("counter did not wrap");
  match_c: cover property (match_pulse != 3'h0);
  irq_c: cover property (irq_req != 6'h00);
  wrap_c: cover property (count_tick && count_value == tmr_pkg::CNT_MAX);
endmodule : tmr_unit_chk

bind tmr_unit tmr_unit_chk i_tmr_unit_chk (.clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
  .bus_rdata, .count_tick, .global_irq_enable, .irq_req, .match_pulse, .count_value);

// [dv/tmr_core_ack.sv]
// Purpose: Core-side interrupt acknowledge model.
// Assumes: Same clock as the unit.
// Notes: Each request is acknowledged once, as it rises, so a lingering one is not cleared twice.
module tmr_core_ack (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Requests in, vector pulses out.
  input wire logic ack_en,
  input wire logic [5:0] irq_req,
  output logic [5:0] vector_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] prev_ff; // Requests seen last cycle.
  logic [5:0] ack_ff; // Vector pulse being issued.
  logic [5:0] nxt_ack; // Next vector pulse.
  // Take only newly raised requests, when enabled.
  always_comb begin
    nxt_ack = ack_en ? (irq_req & ~prev_ff) : 6'h00;
  end
  // Register history and pulse.
  always_ff @(posedge clk) begin
    prev_ff <= rstn ? irq_req : 6'h00;
    ack_ff <= rstn ? nxt_ack : 6'h00;
  end
  assign vector_ack = ack_ff;
endmodule : tmr_core_ack

// [dv/test_tmr_unit.sv]
// Purpose: Self-checking bench for the timer register unit.
// Assumes: Bus strobes are one-cycle pulses; read data valid a cycle later.
// Notes: The counter is only changed while ticks are stopped.
module test_tmr_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, count_tick = 1'b0;
  logic global_irq_enable = 1'b0, capture_use_comparator = 1'b0, capture_rising_edge = 1'b1;
  logic capture_input_pin = 1'b0, comparator_out = 1'b0, ack_en = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic [5:0] vector_ack, irq_req;
  logic [2:0] match_pulse;
  logic [15:0] count_value, w;
  int bad_count = 0, n_checks = 0;
  tmr_unit i_tmr_unit (.clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .count_tick,
    .global_irq_enable, .capture_use_comparator, .capture_rising_edge, .vector_ack,
    .capture_input_pin, .comparator_out, .irq_req, .match_pulse, .count_value);
  tmr_core_ack i_tmr_core_ack (.clk, .rstn, .ack_en, .irq_req, .vector_ack);
  // Free-running system clock.
  initial begin
    forever #4 clk = ~clk;
  end
  // Compare and count.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One write strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  // One read strobe; data is taken once the answering edge has landed.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    #1 d = bus_rdata;
  endtask : rd
  // Word access: high byte first on writes, low byte first on reads.
  task automatic w16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask : w16
  task automatic r16(input logic [3:0] a, input logic [15:0] e);
    rd(a, w[7:0]);
    rd(a + 4'h1, w[15:8]);
    chk("word", e, w);
  endtask : r16
  // Poll the flags a bounded number of times.
  task automatic flags(input logic [7:0] e);
    logic [7:0] f;
    f = ~e;
    for (int k = 0; k < 8 && f !== e; k++) rd(tmr_pkg::ADDR_FLAGS, f);
    chk("flags", {8'h00, e}, {8'h00, f});
  endtask : flags
  // Counter ticks for n cycles.
  task automatic ticks(input int n);
    @(posedge clk);
    count_tick <= 1'b1;
    repeat (n) @(posedge clk);
    count_tick <= 1'b0;
  endtask : ticks
  // Report and stop.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Cut a hang short.
  initial begin
    #500us;
    bad_count++;
    end_sim();
  end
  // Main sequence.
  initial begin
    w = 16'h0000;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], w[7:0]);
      chk("reset", 16'h0000, w);
    end
    wr(tmr_pkg::ADDR_CMPA_HI, 8'h12);
    wr(tmr_pkg::ADDR_CMPB_LO, 8'h34);
    r16(tmr_pkg::ADDR_CMPB_LO, 16'h1234);
    r16(tmr_pkg::ADDR_CMPA_LO, 16'h0000);
    w16(tmr_pkg::ADDR_CNT_LO, 16'hABCD);
    #1 chk("count", 16'hABCD, count_value);
    r16(tmr_pkg::ADDR_CNT_LO, 16'hABCD);
    for (int i = 0; i < 3; i++) w16(tmr_pkg::ADDR_CMPA_LO + 4'(2 * i), 16'h0010);
    wr(tmr_pkg::ADDR_MASK, 8'h2F);
    global_irq_enable <= 1'b1;
    w16(tmr_pkg::ADDR_CNT_LO, 16'h000E);
    ticks(4);
    flags(8'h0E);
    chk("irq", 16'h000E, {10'h000, irq_req});
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq off", 16'h0000, {10'h000, irq_req});
    global_irq_enable <= 1'b1;
    wr(tmr_pkg::ADDR_MASK, 8'h00);
    ack_en <= 1'b1;
    wr(tmr_pkg::ADDR_MASK, 8'h02);
    flags(8'h0C);
    wr(tmr_pkg::ADDR_FLAGS, 8'h04);
    wr(tmr_pkg::ADDR_FLAGS, 8'h00);
    flags(8'h08);
    wr(tmr_pkg::ADDR_FLAGS, 8'hFF);
    flags(8'h00);
    w16(tmr_pkg::ADDR_CNT_LO, 16'h0010);
    count_tick <= 1'b1;
    @(posedge clk);
    count_tick <= 1'b0;
    repeat (3) @(posedge clk);
    flags(8'h00);
    w16(tmr_pkg::ADDR_CNT_LO, 16'h1234);
    capture_input_pin <= 1'b1;
    flags(8'h20);
    r16(tmr_pkg::ADDR_CAP_LO, 16'h1234);
    capture_use_comparator <= 1'b1;
    w16(tmr_pkg::ADDR_CNT_LO, 16'h5678);
    wr(tmr_pkg::ADDR_FLAGS, 8'h20);
    comparator_out <= 1'b1;
    flags(8'h20);
    r16(tmr_pkg::ADDR_CAP_LO, 16'h5678);
    wr(tmr_pkg::ADDR_MASK, 8'h22);
    flags(8'h00);
    w16(tmr_pkg::ADDR_CNT_LO, 16'hFFFF);
    ticks(1);
    #1 chk("wrap", 16'h0000, count_value);
    flags(8'h01);
    chk("irq masked", 16'h0000, {10'h000, irq_req});
    end_sim();
  end
endmodule : test_tmr_unit
